// file: hw/iscm_pkg.sv
// shared types and constants for the instruction state count model
// assumes a single system clock; one execution state is one clock cycle
package iscm_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int BASE_W  = 8;     // base count plus table width
    localparam int ADJ_W   = 2;     // alignment adjustment width
    localparam int BYTE_W  = 4;     // operand byte count width
    localparam int FETCH_W = 4;     // instruction fetch count width
    localparam int EXTRA_W = 8;     // wait plus extra bus state width
    localparam int CNT_W   = 10;    // total state count width

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int STATE_CLK_PER   = 1;    // clock cycles per state
    localparam int REF_CLK_MHZ     = 10;   // reference clock rate
    localparam int REF_STATE_NS    = 100;  // state length at that rate
    localparam int MCLK_PERIOD_NS  = 25;   // this design's clock period
    localparam int MCLK_STATE_NS   = MCLK_PERIOD_NS * STATE_CLK_PER;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

    // ****************************************************************
    // bus areas that a fetch or an operand can sit in
    // ****************************************************************
    typedef enum logic [2:0] {
        ISCM_AREA_W16_S2 = 3'h0,   // 16-bit bus, 2-state access
        ISCM_AREA_W16_S3 = 3'h1,   // 16-bit bus, 3-state access
        ISCM_AREA_W8_S3  = 3'h2,   // 8-bit bus, 3-state access
        ISCM_AREA_W8_S2  = 3'h3,   // 8-bit bus, 2-state access
        ISCM_AREA_MODULE = 3'h4,   // on-chip supporting module
        ISCM_AREA_GREG   = 3'h5    // general register or no operand
    } iscm_area_e;

    // control states, gray along idle -> run -> done
    typedef enum logic [1:0] {
        ISCM_ST_IDLE = 2'h0,
        ISCM_ST_RUN  = 2'h1,
        ISCM_ST_DONE = 2'h3
    } iscm_state_e;

    // one instruction to be timed
    typedef struct packed {
        logic [BASE_W-1:0]  base;          // base count for the mode
        logic [ADJ_W-1:0]   align_adj;     // even/odd start adjustment
        logic [BYTE_W-1:0]  op_bytes;      // bytes read or written
        logic [FETCH_W-1:0] fetch_cnt;     // number of fetches
        iscm_area_e         fetch_area;
        iscm_area_e         op_area;
        logic               op_word;       // word operand when set
        logic [EXTRA_W-1:0] extra_bus_state; // waits and extra bus states
    } iscm_req_s;

    // computed timing of one instruction
    typedef struct packed {
        logic [CNT_W-1:0] total;      // states for the instruction
        logic [CNT_W-1:0] bus_term;   // part beyond base and adjust
    } iscm_res_s;

endpackage : iscm_pkg

// file: hw/iscm_half_up.sv
// halves a count, rounding a fraction up to the next whole number
// assumes an unsigned input; purely combinational
`timescale 1ns/100ps
module iscm_half_up #(
    parameter int W = 10
) (
    input  wire logic [W-1:0] i_val,
    output logic      [W-1:0] o_half
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (W < 2) begin : g_chk
        $error("iscm_half_up: width too small");
    end

    // shift down, then add the dropped bit back as the round-up
    always_comb begin
        o_half = (i_val >> 1) + {{(W-1){1'b0}}, i_val[0]};
    end
endmodule : iscm_half_up

// file: hw/iscm_state_timer.sv
// down counter that runs one step per clock for a loaded state count
// assumes the loader never loads while the counter is still active
`timescale 1ns/100ps
module iscm_state_timer #(
    parameter int W = 10
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_active,
    output logic              o_last,
    output logic      [W-1:0] o_remaining
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (W < 1) begin : g_chk
        $error("iscm_state_timer: width too small");
    end

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // one state per clock cycle, so the count steps every edge
    always_comb begin
        cnt_next = cnt_reg;
        if (i_load) begin
            cnt_next = i_count;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // status straight from the count register
    assign o_active    = (cnt_reg != '0);
    assign o_last      = (cnt_reg == W'(1));
    assign o_remaining = cnt_reg;
endmodule : iscm_state_timer

// file: hw/iscm_core.sv
// instruction state count model: works out how many states an
// instruction takes from its fetch area and operand area, then times
// that many states on the system clock and reports the end
// assumes the base count and the alignment adjustment come ready made
// from the instruction decoder, one request at a time
//
// Notes on behaviour
// - one state equals one system clock cycle
// - operand term is bytes moved in memory
// - fetch term equals number of instruction fetches
// - fast fetch, 16-bit slow word adds half bytes
// - fast fetch, slow 8-bit word adds twice bytes
// - byte operand in slow area adds bytes
// - 16-bit slow fetch adds half fetch count
// - half fetch count rounds up
// - 8-bit slow fetch: no adjust, twice fetches
// - 8-bit slow fetch, byte: bytes plus twice fetches
// - 16-bit fetch keeps the even/odd adjustment
// - waits and extra bus states add states only when a 3-state area is touched
`timescale 1ns/100ps
module iscm_core
    import iscm_pkg::*;
#(
    parameter int MAX_TOTAL = 1023
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // request from the decoder
    input  wire logic             i_req_valid,
    input  wire iscm_req_s        i_req,
    // result and status
    output logic                  o_req_ready,
    output iscm_res_s             o_res,
    output logic                  o_busy,
    output logic                  o_state_tick,
    output logic      [CNT_W-1:0] o_remaining,
    output logic                  o_done
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the worst sum is base + adjust + 2*(I+J+K) + extra states
    localparam int WORST = (2**BASE_W - 1) + (2**ADJ_W - 1)
                         + 2 * ((2**BYTE_W - 1) + 2 * (2**FETCH_W - 1))
                         + (2**EXTRA_W - 1);

    if (MAX_TOTAL < WORST) begin : g_chk_max
        $error("iscm_core: MAX_TOTAL below the worst sum");
    end

    if (MAX_TOTAL > 2**CNT_W - 1) begin : g_chk_cnt
        $error("iscm_core: MAX_TOTAL does not fit the count width");
    end

    if (MCLK_STATE_NS != MCLK_PERIOD_NS) begin : g_chk_state
        $error("iscm_core: a state must be exactly one clock");
    end

    if (REF_STATE_NS * REF_CLK_MHZ != 1000) begin : g_chk_ref
        $error("iscm_core: reference state length inconsistent");
    end

    // ****************************************************************
    // area classification
    // ****************************************************************
    logic fetch_w16;      // fetch from a 16-bit bus area
    logic fetch_w16_s3;   // fetch from the 16-bit 3-state area
    logic fetch_w8;       // fetch from an 8-bit bus area

    logic op_fast;        // 16-bit 2-state area or register
    logic op_w16_s3;      // operand in the 16-bit 3-state area
    logic op_slow8;       // 8-bit area or supporting module
    logic any_s3;         // some access touches a 3-state area

    // group the areas so the formula only asks three questions;
    // module and register fetch codes count as a 16-bit fetch
    always_comb begin
        fetch_w16_s3 = (i_req.fetch_area == ISCM_AREA_W16_S3);
        fetch_w8     = (i_req.fetch_area == ISCM_AREA_W8_S3)
                     || (i_req.fetch_area == ISCM_AREA_W8_S2);
        fetch_w16    = !fetch_w8;
    end

    // operand side; an 8-bit 3-state operand joins the slow class
    always_comb begin
        op_fast      = (i_req.op_area == ISCM_AREA_W16_S2)
                     || (i_req.op_area == ISCM_AREA_GREG);
        op_w16_s3    = (i_req.op_area == ISCM_AREA_W16_S3);
        op_slow8     = !op_fast && !op_w16_s3;

        // only 3-state areas may add waits
        any_s3       = fetch_w16_s3
                     || (i_req.fetch_area == ISCM_AREA_W8_S3)
                     || op_w16_s3
                     || (i_req.op_area == ISCM_AREA_W8_S3);
    end

    // ****************************************************************
    // widened terms
    // ****************************************************************
    logic [CNT_W-1:0] base_w;
    logic [CNT_W-1:0] adj_w;

    logic [CNT_W-1:0] bytes_w;   // operand bytes moved in memory
    logic [CNT_W-1:0] fetch_w;   // total instruction fetches
    logic [CNT_W-1:0] extra_w;
    logic [CNT_W-1:0] all_w;     // bytes plus fetches

    always_comb begin
        base_w  = CNT_W'(i_req.base);
        adj_w   = CNT_W'(i_req.align_adj);

        // byte and fetch counts of the instruction
        bytes_w = CNT_W'(i_req.op_bytes);
        fetch_w = CNT_W'(i_req.fetch_cnt);
        extra_w = CNT_W'(i_req.extra_bus_state);
        all_w   = bytes_w + fetch_w;
    end

    // ****************************************************************
    // halved terms, fractions rounded up
    // ****************************************************************
    logic [CNT_W-1:0] half_bytes;
    logic [CNT_W-1:0] half_fetch;
    logic [CNT_W-1:0] half_all;

    // a word operand on a slow 16-bit bus moves two bytes a state
    iscm_half_up #(
        .W      (CNT_W)
    ) u_half_bytes (
        .i_val  (bytes_w),
        .o_half (half_bytes)
    );

    // rounding up keeps a late odd fetch from being undercounted
    iscm_half_up #(
        .W      (CNT_W)
    ) u_half_fetch (
        .i_val  (fetch_w),
        .o_half (half_fetch)
    );

    // operand and fetches share the slow bus, so halve them together
    iscm_half_up #(
        .W      (CNT_W)
    ) u_half_all (
        .i_val  (all_w),
        .o_half (half_all)
    );

    // ****************************************************************
    // state formula
    // ****************************************************************
    logic [CNT_W-1:0] bus_term;    // operand and fetch part
    logic [CNT_W-1:0] adj_term;    // alignment part
    logic [CNT_W-1:0] wait_term;   // waits and extra bus states

    logic [CNT_W-1:0] total_raw;
    logic [CNT_W-1:0] total;

    // the alignment term matters only on a 16-bit fetch bus; an 8-bit
    // fetch bus takes byte fetches, so odd starts cost nothing extra
    always_comb begin
        bus_term = '0;
        adj_term = fetch_w16 ? adj_w : '0;

        if (fetch_w8) begin
            // byte-wide fetches cost two states each
            adj_term = '0;
            if (op_fast) begin
                bus_term = fetch_w << 1;
            end else if (op_w16_s3 && i_req.op_word) begin
                bus_term = half_bytes + (fetch_w << 1);
            end else if (i_req.op_word) begin
                bus_term = all_w << 1;
            end else begin
                bus_term = bytes_w + (fetch_w << 1);
            end
        end else if (fetch_w16_s3) begin
            // slow 16-bit fetches cost half a state each
            if (op_fast) begin
                bus_term = half_fetch;
            end else if (op_w16_s3 && i_req.op_word) begin
                bus_term = half_all;
            end else if (op_slow8 && i_req.op_word) begin
                bus_term = (bytes_w << 1) + half_fetch;
            end else begin
                bus_term = bytes_w + half_fetch;
            end
        end else begin
            // 16-bit 2-state fetch; other fetch codes are taken as it
            if (op_fast) begin
                bus_term = '0;
            end else if (op_w16_s3 && i_req.op_word) begin
                bus_term = half_bytes;
            end else if (op_slow8 && i_req.op_word) begin
                bus_term = bytes_w << 1;
            end else begin
                bus_term = bytes_w;
            end
        end

        // extra states only exist when a 3-state area is touched
        wait_term = any_s3 ? extra_w : '0;
        total_raw = base_w + adj_term + bus_term + wait_term;

        // a zero count would never start the timer
        total     = (total_raw == '0) ? CNT_W'(1) : total_raw;
    end

    // ****************************************************************
    // control state machine
    // ****************************************************************
    iscm_state_e      state_reg;
    iscm_state_e      state_next;
    iscm_res_s        res_reg;
    iscm_res_s        res_next;
    logic             accept;

    // timer status
    logic             tmr_active;
    logic             tmr_last;
    logic [CNT_W-1:0] tmr_remaining;

    // a request is taken only while idle; no queue behind it
    // the timer loads on the edge at which the state leaves idle
    assign accept = (state_reg == ISCM_ST_IDLE) && i_req_valid;

    always_comb begin
        state_next = state_reg;
        res_next   = res_reg;
        case (state_reg)
            ISCM_ST_IDLE: begin
                // take a waiting request
                if (i_req_valid) begin
                    res_next.total    = total;
                    res_next.bus_term = bus_term + wait_term;
                    state_next        = ISCM_ST_RUN;
                end
            end

            ISCM_ST_RUN: begin
                // count the states down to the last
                if (tmr_last) begin
                    state_next = ISCM_ST_DONE;
                end
            end

            ISCM_ST_DONE: begin
                // one-cycle end pulse
                state_next = ISCM_ST_IDLE;
            end

            default: begin
                state_next = ISCM_ST_IDLE;
            end
        endcase
    end

    // reset clears the result so no stale total shows
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= ISCM_ST_IDLE;
            res_reg   <= '{total: CNT_RST, bus_term: CNT_RST};
        end else begin
            state_reg <= state_next;
            res_reg   <= res_next;
        end
    end

    // ****************************************************************
    // state timer
    // ****************************************************************
    // each counted step is one clock, which is one state
    iscm_state_timer #(
        .W           (CNT_W)
    ) u_timer (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_load      (accept),
        .i_count     (total),
        .o_active    (tmr_active),
        .o_last      (tmr_last),
        .o_remaining (tmr_remaining)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    // status from the state register; tick also uses the timer, remaining count comes from the timer alone
    assign o_req_ready  = (state_reg == ISCM_ST_IDLE);
    assign o_res        = res_reg;
    assign o_busy       = (state_reg == ISCM_ST_RUN);
    assign o_state_tick = (state_reg == ISCM_ST_RUN) && tmr_active;
    assign o_remaining  = tmr_remaining;
    assign o_done       = (state_reg == ISCM_ST_DONE);

endmodule : iscm_core

// file: verif/iscm_core_sva.sv
// port checker for iscm_core timing and result hand-over
// assumes one clock i_mclk and a synchronous active-high i_rst
`timescale 1ns/100ps
module iscm_core_sva
    import iscm_pkg::*;
#(
    parameter int MAX_TOTAL = 1023
) (
    input wire logic             i_mclk,
    input wire logic             i_rst,
    input wire logic             i_req_valid,
    input wire iscm_req_s        i_req,
    input wire logic             o_req_ready,
    input wire iscm_res_s        o_res,
    input wire logic             o_busy,
    input wire logic             o_state_tick,
    input wire logic [CNT_W-1:0] o_remaining,
    input wire logic             o_done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // accept strobe shared by several properties
    logic acc;
    assign acc = i_req_valid && o_req_ready;

    // ****************************************************************
    // state timing
    // ****************************************************************
    a_busy_blocks_ready: assert property (o_busy |-> !o_req_ready)
        else $error("ready high while timing");
    a_accept_loads: assert property (acc |=> o_busy && o_remaining == o_res.total)
        else $error("timer not loaded with total");
    a_count_down: assert property (o_busy && o_remaining > 10'h1
        |=> o_busy && o_remaining == $past(o_remaining) - 10'h1)
        else $error("state count did not step by one");
    a_last_then_done: assert property (o_busy && o_remaining == 10'h1 |=> o_done && !o_busy)
        else $error("done missing after last state");
    a_done_one_pulse: assert property (o_done |=> !o_done && o_req_ready)
        else $error("done longer than one cycle");
    a_done_idle: assert property (o_done |-> !o_busy && o_remaining == 10'h0)
        else $error("done while still counting");
    a_tick_per_state: assert property (o_state_tick == o_busy)
        else $error("tick disagrees with busy");

    // ****************************************************************
    // result values
    // ****************************************************************
    a_res_hold: assert property (!acc |=> $stable(o_res))
        else $error("result changed without accept");
    a_total_covers_bus: assert property (o_busy |-> o_res.total >= o_res.bus_term && o_res.total != 10'h0
        && o_res.total <= MAX_TOTAL)
        else $error("total below bus term");
    // a register operand on a fast fetch costs only base plus adjustment
    a_reg_base_only: assert property (acc && i_req.base != 8'h0 && i_req.fetch_area == ISCM_AREA_W16_S2
        && i_req.op_area == ISCM_AREA_GREG |=> o_res.bus_term == 10'h0
        && o_res.total == 10'($past(i_req.base)) + 10'($past(i_req.align_adj)))
        else $error("register operand added bus states");

    c_accept: cover property (acc);
    c_done: cover property (o_done);
    c_slow_fetch: cover property (acc && i_req.fetch_area == ISCM_AREA_W8_S3);
endmodule : iscm_core_sva

bind iscm_core iscm_core_sva #(.MAX_TOTAL(MAX_TOTAL)) sva_u (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_res(o_res),
    .o_busy(o_busy), .o_state_tick(o_state_tick), .o_remaining(o_remaining), .o_done(o_done));

// file: verif/iscm_mem_model.sv
// memory side model: reports the wait and extra bus states of an access
// assumes the bench sets the wait count it wants the slow areas to show
`timescale 1ns/100ps
module iscm_mem_model
    import iscm_pkg::*;
(
    input  wire iscm_area_e         i_fetch_area,
    input  wire iscm_area_e         i_op_area,
    input  wire logic [EXTRA_W-1:0] i_wait_states,
    output logic      [EXTRA_W-1:0] o_extra
);
    // only 3-state areas stretch a bus cycle; fast areas and registers never wait
    always_comb begin
        if (i_fetch_area inside {ISCM_AREA_W16_S3, ISCM_AREA_W8_S3}
            || i_op_area inside {ISCM_AREA_W16_S3, ISCM_AREA_W8_S3}) begin
            o_extra = i_wait_states;
        end else begin
            o_extra = 8'h00;
        end
    end
endmodule : iscm_mem_model

// file: verif/test_iscm_core.sv
// self-checking bench for iscm_core with the memory wait model beside it
// assumes a 40 MHz clock and a synchronous active-high reset
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module test_iscm_core
    import iscm_pkg::*;
;
    logic             i_mclk = 1'b0;
    logic             i_rst;
    logic             i_req_valid;
    iscm_req_s        req_drv;
    iscm_req_s        req_bus;
    logic [EXTRA_W-1:0] mem_extra;
    logic             o_req_ready;
    iscm_res_s        o_res;
    logic             o_busy;
    logic             o_state_tick;
    logic [CNT_W-1:0] o_remaining;
    logic             o_done;
    int               num_errors = 0;
    int               n_tests = 0;

    always #12.5 i_mclk = ~i_mclk;

    // wait states come from the memory model, not from the bench directly
    always_comb begin
        req_bus = req_drv;
        req_bus.extra_bus_state = mem_extra;
    end

    iscm_mem_model mem_u (.i_fetch_area(req_drv.fetch_area), .i_op_area(req_drv.op_area),
        .i_wait_states(req_drv.extra_bus_state), .o_extra(mem_extra));
    iscm_core #(.MAX_TOTAL(1023)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid),
        .i_req(req_bus), .o_req_ready(o_req_ready), .o_res(o_res), .o_busy(o_busy),
        .o_state_tick(o_state_tick), .o_remaining(o_remaining), .o_done(o_done));

    // ****************************************************************
    // expected values
    // ****************************************************************
    function automatic iscm_req_s mk(input logic [7:0] b, input logic [1:0] a, input logic [3:0] i,
        input logic [3:0] j, input iscm_area_e fa, input iscm_area_e oa, input logic w, input logic [7:0] x);
        return '{b, a, i, j, fa, oa, w, x};
    endfunction : mk

    // bus part of the count; a 16-bit 3-state fetch rounds its half up
    function automatic int exp_bus(input iscm_req_s r);
        int i, jk, h, b;
        bit fast, s16;
        i    = r.op_bytes;
        jk   = r.fetch_cnt;
        h    = (jk + 1) / 2;
        fast = r.op_area inside {ISCM_AREA_W16_S2, ISCM_AREA_GREG};
        s16  = r.op_area == ISCM_AREA_W16_S3;
        if (r.fetch_area inside {ISCM_AREA_W8_S3, ISCM_AREA_W8_S2})
            b = fast ? 2*jk : (s16 && r.op_word) ? (i+1)/2 + 2*jk : r.op_word ? 2*(i+jk) : i + 2*jk;
        else if (r.fetch_area == ISCM_AREA_W16_S3)
            b = fast ? h : !r.op_word ? i + h : s16 ? (i+jk+1)/2 : 2*i + h;
        else
            b = fast ? 0 : !r.op_word ? i : s16 ? (i+1)/2 : 2*i;
        if (r.fetch_area inside {ISCM_AREA_W16_S3, ISCM_AREA_W8_S3}
            || r.op_area inside {ISCM_AREA_W16_S3, ISCM_AREA_W8_S3}) b += r.extra_bus_state;
        return b;
    endfunction : exp_bus

    function automatic int exp_tot(input iscm_req_s r);
        int t;
        t = r.base + exp_bus(r);
        if (!(r.fetch_area inside {ISCM_AREA_W8_S3, ISCM_AREA_W8_S2})) t += r.align_adj;
        return (t == 0) ? 1 : t;
    endfunction : exp_tot

    // ****************************************************************
    // drivers and scenarios
    // ****************************************************************
    task automatic print_verdict;
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // one request, held until taken, then the whole state window is timed
    task automatic run_req(input iscm_req_s r, input int et, output logic [CNT_W-1:0] t, b);
        int n, k;
        n = 0;
        k = 0;
        @(posedge i_mclk);
        req_drv     <= r;
        i_req_valid <= 1'b1;
        do begin @(negedge i_mclk); n++; end while (o_req_ready !== 1'b1 && n < 50);
        if (o_req_ready !== 1'b1) begin num_errors++; print_verdict; end
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        @(negedge i_mclk);
        t = o_res.total;
        b = o_res.bus_term;
        `CHK("remaining", CNT_W'(et), o_remaining)
        n = 0;
        while (o_busy === 1'b1 && n < 1100) begin n++; k += int'(o_state_tick === 1'b1); @(negedge i_mclk); end
        if (o_busy === 1'b1) begin num_errors++; print_verdict; end
        `CHK("busy_cycles", et, n)
        `CHK("tick_cycles", et, k)
        `CHK("done", 1'b1, o_done)
        @(negedge i_mclk);
        `CHK("ready", 1'b1, o_req_ready)
    endtask : run_req

    task automatic try_req(input iscm_req_s r, input int lit);
        logic [CNT_W-1:0] t, b;
        run_req(r, exp_tot(r), t, b);
        `CHK("total", CNT_W'(exp_tot(r)), t)
        `CHK("bus_term", CNT_W'(exp_bus(r)), b)
        if (lit >= 0) `CHK("worked_total", CNT_W'(lit), t)
    endtask : try_req

    // worked cases with fixed answers, even and odd start
    task automatic t_examples;
        try_req(mk(5, 1, 2, 2, ISCM_AREA_W16_S2, ISCM_AREA_GREG, 1, 0), 6);
        try_req(mk(5, 0, 2, 2, ISCM_AREA_W16_S2, ISCM_AREA_W16_S2, 1, 0), 5);
        try_req(mk(9, 0, 2, 1, ISCM_AREA_W16_S2, ISCM_AREA_MODULE, 1, 0), 13);
        try_req(mk(9, 1, 2, 1, ISCM_AREA_W16_S2, ISCM_AREA_W8_S2, 1, 0), 14);
        try_req(mk(5, 1, 2, 2, ISCM_AREA_W8_S3, ISCM_AREA_GREG, 1, 0), 9);
    endtask : t_examples

    // odd fetch counts must round the half up
    task automatic t_round;
        for (int j = 1; j <= 8; j++)
            try_req(mk(4, 0, 0, 4'(j), ISCM_AREA_W16_S3, ISCM_AREA_GREG, 0, 0), 4 + (j + 1) / 2);
    endtask : t_round

    // slow memory stretches by its waits; a supporting module answers promptly
    task automatic t_waits;
        try_req(mk(2, 0, 1, 1, ISCM_AREA_W16_S2, ISCM_AREA_W16_S3, 0, 8'h00), 3);
        try_req(mk(2, 0, 1, 1, ISCM_AREA_W16_S2, ISCM_AREA_W16_S3, 0, 8'h01), 4);
        try_req(mk(2, 0, 1, 1, ISCM_AREA_W16_S2, ISCM_AREA_W16_S3, 0, 8'hff), 258);
        try_req(mk(2, 0, 1, 1, ISCM_AREA_W16_S2, ISCM_AREA_MODULE, 0, 8'h09), 3);
    endtask : t_waits

    // every fetch area against every operand area, byte and word
    task automatic t_matrix;
        for (int fa = 0; fa < 6; fa++)
            for (int oa = 0; oa < 6; oa++)
                for (int w = 0; w < 2; w++)
                    try_req(mk(3, 1, 3, 3, iscm_area_e'(fa), iscm_area_e'(oa), 1'(w), 2), -1);
    endtask : t_matrix

    // a request held while busy is not taken until the window ends
    task automatic t_refused;
        @(posedge i_mclk);
        req_drv     <= mk(6, 0, 0, 1, ISCM_AREA_W16_S2, ISCM_AREA_GREG, 0, 0);
        i_req_valid <= 1'b1;
        @(posedge i_mclk);
        req_drv     <= mk(3, 0, 0, 1, ISCM_AREA_W16_S2, ISCM_AREA_GREG, 0, 0);
        repeat (6) begin @(negedge i_mclk); `CHK("held_total", 10'h006, o_res.total) end
        @(negedge i_mclk);
        `CHK("done_after_six", 1'b1, o_done)
        @(negedge i_mclk);
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        @(negedge i_mclk);
        `CHK("second_total", 10'h003, o_res.total)
        repeat (4) @(negedge i_mclk);
    endtask : t_refused

    // reset in mid-count returns every output to idle
    task automatic t_reset_mid;
        @(posedge i_mclk);
        req_drv     <= mk(40, 0, 0, 1, ISCM_AREA_W16_S2, ISCM_AREA_GREG, 0, 0);
        i_req_valid <= 1'b1;
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        `CHK("rst_busy", 1'b0, o_busy)
        `CHK("rst_ready", 1'b1, o_req_ready)
        `CHK("rst_res", 20'h00000, o_res)
        `CHK("rst_remaining", 10'h000, o_remaining)
    endtask : t_reset_mid

    initial begin
        i_rst       = 1'b1;
        i_req_valid = 1'b0;
        req_drv     = '0;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_examples;
        t_round;
        t_waits;
        t_matrix;
        t_refused;
        t_reset_mid;
        try_req(mk(0, 0, 0, 1, ISCM_AREA_W16_S2, ISCM_AREA_GREG, 0, 0), 1);
        print_verdict;
    end

    // hang guard, well past the longest run
    initial begin
        #2500000;
        num_errors++;
        print_verdict;
    end
endmodule : test_iscm_core
